/* verilog/gsps_consts.svh */
`ifndef GSPS_CONSTS_SVH
`define GSPS_CONSTS_SVH
`define GSPS_SEL_RX_THR_PKT   6'h01
`define GSPS_SEL_TX_THR       6'h02
`define GSPS_SEL_TX_FULL      6'h03
`define GSPS_SEL_RX_OVF       6'h04
`define GSPS_SEL_TX_UNF       6'h05
`define GSPS_SEL_SYNC_PKT     6'h06
`define GSPS_SEL_CRC_PKT      6'h07
`define GSPS_SEL_PREAMBLE_Q   6'h08
`define GSPS_SEL_CHAN_ASSESS  6'h09
`define GSPS_SEL_LOCK         6'h0A
`define GSPS_SEL_SER_CLK      6'h0B
`define GSPS_SEL_SER_SYNC     6'h0C
`define GSPS_SEL_SER_ASYNC    6'h0D
`define GSPS_SEL_TEST_LO      6'h10
`define GSPS_SEL_TEST_HI      6'h14
`define GSPS_REG_SEL0         4'h0
`define GSPS_REG_SEL1         4'h1
`define GSPS_REG_SEL2         4'h2
`define GSPS_REG_INV          4'h3
`define GSPS_REG_PINS         4'h4
`define GSPS_REG_IRQ_STAT     4'h5
`define GSPS_REG_IRQ_MASK     4'h6
`define GSPS_SEL0_RESET       6'h0B
`define GSPS_SEL1_RESET       6'h0A
`define GSPS_SEL2_RESET       6'h01
`define GSPS_INV_RESET        3'h0
`define GSPS_MASK_RESET       3'h0
`endif

/* verilog/gsps_pkg.sv */
package gsps_pkg;
  typedef logic [5:0] gsps_sel_t;
  typedef enum logic [1:0] {
    GSPS_PKT_IDLE = 2'b00,
    GSPS_PKT_RX   = 2'b01,
    GSPS_PKT_TX   = 2'b10
  } gsps_pkt_e;
endpackage : gsps_pkg

/* verilog/gsps_pin_mux.sv */
`timescale 1ns/1ns
`include "gsps_consts.svh"
module gsps_pin_mux (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire gsps_pkg::gsps_sel_t sel_in,
  input  wire logic              invert_in,
  input  wire logic [13:1]       src_in,
  output logic                   pin_out
);
  typedef struct packed {
    logic pin;
  } gsps_mux_s;

  gsps_mux_s state;
  gsps_mux_s next_state;
  logic      picked;

  always_comb begin
    picked = 1'b0;
    if (sel_in >= `GSPS_SEL_RX_THR_PKT && sel_in <= `GSPS_SEL_SER_ASYNC) begin
      picked = src_in[sel_in[3:0]];
    end
    next_state.pin = picked ^ invert_in;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pin_out = state.pin;

  a_pin_follows: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pin_out == ($past(picked) ^ $past(invert_in)))
    else $error("pin does not follow selected source");
endmodule : gsps_pin_mux

/* verilog/gsps_status_pins.sv */
`timescale 1ns/1ns
`include "gsps_consts.svh"
module gsps_status_pins (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [7:0]       rdata_out,
  output logic             irq_out,
  input  wire logic [6:0]  rx_fill_in,
  input  wire logic [6:0]  tx_fill_in,
  input  wire logic [6:0]  rx_fill_threshold_in,
  input  wire logic [6:0]  tx_fill_threshold_in,
  input  wire logic        tx_full_in,
  input  wire logic        rx_overflow_in,
  input  wire logic        tx_underflow_in,
  input  wire logic        rx_flush_in,
  input  wire logic        tx_flush_in,
  input  wire logic        sync_found_in,
  input  wire logic        pkt_end_in,
  input  wire logic        tx_mode_in,
  input  wire logic        addr_fail_in,
  input  wire logic        crc_ok_pkt_in,
  input  wire logic        rx_first_read_in,
  input  wire logic        pq_above_in,
  input  wire logic        rssi_below_in,
  input  wire logic        lock_det_in,
  input  wire logic        ser_clk_in,
  input  wire logic        ser_data_in,
  input  wire logic        ser_async_in,
  input  wire logic        chip_select_n_in,
  output logic             pin0_out,
  output logic             pin1_out,
  output logic             pin1_oe_out,
  output logic             pin2_out
);
  typedef struct packed {
    gsps_pkg::gsps_sel_t [2:0] sel;
    logic [2:0]                inv;
    logic [2:0]                stat;
    logic [2:0]                mask;
    logic [2:0]                pin_q;
    logic [7:0]                rdata;
    logic                      rx_thr;
    logic                      tx_full;
    logic                      rx_ovf;
    logic                      tx_unf;
    gsps_pkg::gsps_pkt_e       pkt;
    logic                      crc;
    logic [3:0]                pins_s1;
    logic [3:0]                pins_s2;
    logic                      cs_s1;
    logic                      cs_s2;
  } gsps_top_s;

  gsps_top_s   state;
  gsps_top_s   next_state;
  logic [13:1] src;
  logic [2:0]  pin_raw;
  logic [2:0]  rise;

  always_comb begin
    next_state = state;
    // pins from the analog side and the host pass two flops first
    next_state.pins_s1 = {lock_det_in, ser_clk_in, ser_data_in, ser_async_in};
    next_state.pins_s2 = state.pins_s1;
    next_state.cs_s1   = chip_select_n_in;
    next_state.cs_s2   = state.cs_s1;
    if (rx_fill_in >= rx_fill_threshold_in || pkt_end_in) begin
      next_state.rx_thr = 1'b1;
    end else if (rx_fill_in == 7'h00) begin
      next_state.rx_thr = 1'b0;
    end
    if (tx_full_in) begin
      next_state.tx_full = 1'b1;
    end else if (tx_fill_in < tx_fill_threshold_in) begin
      next_state.tx_full = 1'b0;
    end
    // overflow flag; the event wins over a same-cycle flush
    if (rx_overflow_in) begin
      next_state.rx_ovf = 1'b1;
    end else if (rx_flush_in) begin
      next_state.rx_ovf = 1'b0;
    end
    if (tx_underflow_in) begin
      next_state.tx_unf = 1'b1;
    end else if (tx_flush_in) begin
      next_state.tx_unf = 1'b0;
    end
    case (state.pkt)
      gsps_pkg::GSPS_PKT_IDLE: begin
        if (sync_found_in) begin
          next_state.pkt = tx_mode_in ? gsps_pkg::GSPS_PKT_TX : gsps_pkg::GSPS_PKT_RX;
        end
      end
      gsps_pkg::GSPS_PKT_RX: begin
        if (pkt_end_in || addr_fail_in || rx_overflow_in) begin
          next_state.pkt = gsps_pkg::GSPS_PKT_IDLE;
        end
      end
      gsps_pkg::GSPS_PKT_TX: begin
        if (pkt_end_in || tx_underflow_in) begin
          next_state.pkt = gsps_pkg::GSPS_PKT_IDLE;
        end
      end
      default: next_state.pkt = gsps_pkg::GSPS_PKT_IDLE;
    endcase
    if (crc_ok_pkt_in) begin
      next_state.crc = 1'b1;
    end else if (rx_first_read_in) begin
      next_state.crc = 1'b0;
    end
    // interrupt status: rising pin edges; a new edge beats the read clear
    if (rd_in && addr_in == `GSPS_REG_IRQ_STAT) begin
      next_state.stat = 3'h0;
    end
    next_state.stat = next_state.stat | rise;
    next_state.pin_q = pin_raw;
    next_state.rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `GSPS_REG_SEL0:     next_state.rdata = {2'h0, state.sel[0]};
        `GSPS_REG_SEL1:     next_state.rdata = {2'h0, state.sel[1]};
        `GSPS_REG_SEL2:     next_state.rdata = {2'h0, state.sel[2]};
        `GSPS_REG_INV:      next_state.rdata = {5'h00, state.inv};
        `GSPS_REG_PINS:     next_state.rdata = {5'h00, pin_raw};
        `GSPS_REG_IRQ_STAT: next_state.rdata = {5'h00, state.stat};
        `GSPS_REG_IRQ_MASK: next_state.rdata = {5'h00, state.mask};
        default:            next_state.rdata = 8'h00;
      endcase
    end
    if (wr_in) begin
      case (addr_in)
        `GSPS_REG_SEL0:     next_state.sel[0] = wdata_in[5:0];
        `GSPS_REG_SEL1:     next_state.sel[1] = wdata_in[5:0];
        `GSPS_REG_SEL2:     next_state.sel[2] = wdata_in[5:0];
        `GSPS_REG_INV:      next_state.inv = wdata_in[2:0];
        `GSPS_REG_IRQ_MASK: next_state.mask = wdata_in[2:0];
        default:            next_state.inv = state.inv;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state         <= '0;
      state.sel[0]  <= `GSPS_SEL0_RESET;
      state.sel[1]  <= `GSPS_SEL1_RESET;
      state.sel[2]  <= `GSPS_SEL2_RESET;
      state.inv     <= `GSPS_INV_RESET;
      state.mask    <= `GSPS_MASK_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    src     = '0;
    src[1]  = state.rx_thr;
    src[2]  = tx_fill_in >= tx_fill_threshold_in;
    src[3]  = state.tx_full;
    src[4]  = state.rx_ovf;
    src[5]  = state.tx_unf;
    src[6]  = state.pkt != gsps_pkg::GSPS_PKT_IDLE;
    src[7]  = state.crc;
    src[8]  = pq_above_in;
    src[9]  = rssi_below_in;
    src[10] = state.pins_s2[3];
    src[11] = state.pins_s2[2];
    // data launched on falling clock by the modem, kept aligned with src[11]
    src[12] = state.pins_s2[1];
    src[13] = state.pins_s2[0];
  end

  // test codes 16..20 and all unlisted codes select a constant low source, so the pin is low unless its invert bit is set
  for (genvar i = 0; i < 3; i++) begin : g_pin
    gsps_pin_mux u_mux (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .sel_in    (state.sel[i]),
      .invert_in (state.inv[i]),
      .src_in    (src),
      .pin_out   (pin_raw[i])
    );
  end

  assign rise      = pin_raw & ~state.pin_q;
  assign rdata_out = state.rdata;
  assign irq_out   = |(state.stat & state.mask);
  assign pin0_out  = pin_raw[0];
  assign pin2_out  = pin_raw[2];
  // shared pin driven only while chip select high
  assign pin1_out    = pin_raw[1];
  assign pin1_oe_out = state.cs_s2;

  // a flag set on one edge reaches the pin through the mux flop one edge later
  sequence s_sel2_ovf;
    state.sel[2] == `GSPS_SEL_RX_OVF && !state.inv[2];
  endsequence
  // two sync flops: a pin level held for three samples has reached the logic
  sequence s_lock_high;
    lock_det_in [*3];
  endsequence
  sequence s_cs_high;
    chip_select_n_in [*3];
  endsequence
  sequence s_cs_low;
    !chip_select_n_in [*3];
  endsequence

  a_ovf_held: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state.rx_ovf && !rx_flush_in |=> state.rx_ovf)
    else $error("overflow flag dropped without flush");
  a_ovf_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rx_overflow_in |=> state.rx_ovf)
    else $error("overflow flag not raised");
  a_ovf_pin: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rx_overflow_in ##0 s_sel2_ovf ##1 s_sel2_ovf |=> pin2_out)
    else $error("overflow not shown on pin");
  a_unf_flush: assert property (@(posedge clk_in) disable iff (!nrst_in)
    tx_flush_in && !tx_underflow_in |=> !state.tx_unf)
    else $error("underflow flag not cleared by flush");
  a_unf_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    tx_underflow_in |=> state.tx_unf)
    else $error("underflow flag not raised");
  a_rx_empty: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rx_fill_in == 7'h00 && rx_fill_threshold_in != 7'h00 && !pkt_end_in |=> !state.rx_thr)
    else $error("rx threshold flag not cleared on empty");
  a_rx_rise: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rx_fill_in >= rx_fill_threshold_in |=> state.rx_thr)
    else $error("rx threshold flag not raised");
  a_tx_level: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state.sel[2] == `GSPS_SEL_TX_THR && !state.inv[2] && tx_fill_in < tx_fill_threshold_in
    |=> !pin2_out)
    else $error("tx threshold pin high below threshold");
  a_tx_full: assert property (@(posedge clk_in) disable iff (!nrst_in)
    tx_full_in |=> state.tx_full)
    else $error("tx full flag not raised");
  a_tx_drop: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state.tx_full && !tx_full_in && tx_fill_in < tx_fill_threshold_in |=> !state.tx_full)
    else $error("tx full flag kept below threshold");
  a_sync_start: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state.pkt == gsps_pkg::GSPS_PKT_IDLE && sync_found_in |=> src[6])
    else $error("packet window not opened");
  a_pkt_end: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state.pkt != gsps_pkg::GSPS_PKT_IDLE && pkt_end_in
    |=> state.pkt == gsps_pkg::GSPS_PKT_IDLE)
    else $error("packet window kept after packet end");
  a_rx_early: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state.pkt == gsps_pkg::GSPS_PKT_RX && addr_fail_in
    |=> state.pkt == gsps_pkg::GSPS_PKT_IDLE)
    else $error("packet window kept after address fail");
  a_rx_ovf_end: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state.pkt == gsps_pkg::GSPS_PKT_RX && rx_overflow_in
    |=> state.pkt == gsps_pkg::GSPS_PKT_IDLE)
    else $error("packet window kept after overflow");
  a_tx_early: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state.pkt == gsps_pkg::GSPS_PKT_TX && tx_underflow_in
    |=> state.pkt == gsps_pkg::GSPS_PKT_IDLE)
    else $error("packet window kept after underflow");
  a_crc_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    crc_ok_pkt_in |=> state.crc)
    else $error("good packet flag not raised");
  a_crc_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rx_first_read_in && !crc_ok_pkt_in |=> !state.crc)
    else $error("good packet flag not cleared on read");
  a_chan_pin: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state.sel[2] == `GSPS_SEL_CHAN_ASSESS && !state.inv[2] && rssi_below_in |=> pin2_out)
    else $error("channel assessment not shown on pin");
  a_lock_sync: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_lock_high |-> src[10])
    else $error("lock level not passed through sync");
  a_oe_high: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_cs_high |-> pin1_oe_out)
    else $error("shared pin not driven while deselected");
  a_oe_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_cs_low |-> !pin1_oe_out)
    else $error("shared pin driven while selected");
  a_stat_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rise[2] |=> state.stat[2])
    else $error("status bit lost on pin edge");
  a_stat_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == `GSPS_REG_IRQ_STAT && rise == 3'h0 |=> state.stat == 3'h0)
    else $error("status not cleared by read");
endmodule : gsps_status_pins

/* testbench/gsps_host_model.sv */
`timescale 1ns/1ns
module gsps_host_model (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       clk_pin_in,
  input  wire logic       data_pin_in,
  output logic            chip_select_n_out,
  output logic [7:0]      edges_out,
  output logic            sample_out
);
  logic last;
  initial chip_select_n_out = 1'b0;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last <= 1'b0;
      edges_out <= 8'h00;
    end else begin
      last <= data_pin_in;
      if (data_pin_in && !last) begin
        edges_out <= edges_out + 8'h01;
      end
    end
  end
  always @(posedge clk_pin_in) begin
    sample_out <= data_pin_in;
  end
  task automatic select_dev(input logic on);
    chip_select_n_out <= !on;
  endtask : select_dev
endmodule : gsps_host_model

/* testbench/gsps_status_pins_tb_top.sv */
`timescale 1ns/1ns
`include "gsps_consts.svh"
module gsps_status_pins_tb_top;
  logic       clk_in = 1'b0, nrst_in = 1'b0, wr = 1'b0, rd = 1'b0, txm = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, edges, d, e0;
  logic [6:0] rxf = 7'h00, txf = 7'h00;
  logic [9:0] ev = 10'h000;
  logic [5:0] lv = 6'h00;
  logic       irq, p0, p1, oe, p2, chip_select_n, smp;
  int         mismatches = 0, total_checks = 0, cycles = 0;
  always #50 clk_in = ~clk_in;
  gsps_status_pins dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .rx_fill_in(rxf),
    .tx_fill_in(txf), .rx_fill_threshold_in(7'h08), .tx_fill_threshold_in(7'h08),
    .tx_full_in(ev[0]), .rx_overflow_in(ev[1]), .tx_underflow_in(ev[2]), .rx_flush_in(ev[3]),
    .tx_flush_in(ev[4]), .sync_found_in(ev[5]), .pkt_end_in(ev[6]), .tx_mode_in(txm),
    .addr_fail_in(ev[7]), .crc_ok_pkt_in(ev[8]), .rx_first_read_in(ev[9]),
    .pq_above_in(lv[0]), .rssi_below_in(lv[1]), .lock_det_in(lv[2]), .ser_clk_in(lv[3]),
    .ser_data_in(lv[4]), .ser_async_in(lv[5]), .chip_select_n_in(chip_select_n), .pin0_out(p0),
    .pin1_out(p1), .pin1_oe_out(oe), .pin2_out(p2));
  gsps_host_model host (.clk_in(clk_in), .nrst_in(nrst_in), .clk_pin_in(p0),
    .data_pin_in(p2), .chip_select_n_out(chip_select_n), .edges_out(edges), .sample_out(smp));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp
  task automatic wrr(input logic [3:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask : wrr
  task automatic rdr(input logic [3:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    v = rdata;
    @(posedge clk_in);
  endtask : rdr
  task automatic see(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : see
  task automatic pin(input logic e);
    see(6);
    cmp({7'h00, e}, {7'h00, p2});
    @(posedge clk_in);
  endtask : pin
  task automatic pulse(input int k);
    ev <= 10'h001 << k;
    @(posedge clk_in);
    ev <= 10'h000;
    @(posedge clk_in);
  endtask : pulse
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    rdr(`GSPS_REG_SEL0, d);
    cmp({2'b00, `GSPS_SEL0_RESET}, d);
    rdr(`GSPS_REG_SEL2, d);
    cmp({2'b00, `GSPS_SEL2_RESET}, d);
    wrr(4'hF, 8'hFF);
    rdr(4'hF, d);
    cmp(8'h00, d);
    rxf <= 7'h08;
    pin(1'b1);
    rxf <= 7'h07;
    pin(1'b1);
    rxf <= 7'h00;
    pin(1'b0);
    rxf <= 7'h03;
    pin(1'b0);
    pulse(6);
    pin(1'b1);
    rxf <= 7'h00;
    pin(1'b0);
    wrr(`GSPS_REG_SEL2, 8'h02);
    txf <= 7'h08;
    pin(1'b1);
    txf <= 7'h07;
    pin(1'b0);
    wrr(`GSPS_REG_SEL2, 8'h03);
    txf <= 7'h09;
    pin(1'b0);
    pulse(0);
    pin(1'b1);
    txf <= 7'h08;
    pin(1'b1);
    txf <= 7'h07;
    pin(1'b0);
    for (int k = 0; k < 2; k++) begin
      wrr(`GSPS_REG_SEL2, 8'h04 + k[7:0]);
      pulse(1 + k);
      pin(1'b1);
      pin(1'b1);
      pulse(3 + k);
      pin(1'b0);
    end
    wrr(`GSPS_REG_SEL2, 8'h06);
    pulse(5);
    pin(1'b1);
    pulse(6);
    pin(1'b0);
    for (int k = 0; k < 2; k++) begin
      pulse(5);
      pin(1'b1);
      pulse(k == 0 ? 7 : 1);
      pin(1'b0);
    end
    pulse(3);
    txm <= 1'b1;
    pulse(5);
    pin(1'b1);
    pulse(2);
    pin(1'b0);
    pulse(4);
    txm <= 1'b0;
    wrr(`GSPS_REG_SEL2, 8'h07);
    pulse(8);
    pin(1'b1);
    pulse(9);
    pin(1'b0);
    e0 = edges;
    for (int i = 0; i < 6; i++) begin
      wrr(`GSPS_REG_SEL2, 8'h08 + i[7:0]);
      lv <= 6'h01 << i;
      pin(1'b1);
      cmp({7'h00, i == 2}, {7'h00, p1});
      lv <= 6'h00;
      pin(1'b0);
      cmp(8'h00, {7'h00, p1});
    end
    cmp(e0 + 8'h06, edges);
    wrr(`GSPS_REG_SEL2, 8'h0C);
    for (int b = 1; b >= 0; b--) begin
      lv <= {1'b0, b[0], 4'h0};
      see(6);
      lv <= {1'b0, b[0], 4'h8};
      see(6);
      cmp({7'h00, b[0]}, {7'h00, smp});
      @(posedge clk_in);
    end
    // serial data high so the unlisted code must really pull the pin low
    lv <= 6'h10;
    wrr(`GSPS_REG_SEL2, 8'h0F);
    pin(1'b0);
    wrr(`GSPS_REG_INV, 8'h04);
    pin(1'b1);
    cmp(8'h00, {7'h00, p0});
    wrr(`GSPS_REG_INV, 8'h00);
    host.select_dev(1'b0);
    see(6);
    cmp(8'h01, {7'h00, oe});
    host.select_dev(1'b1);
    see(6);
    cmp(8'h00, {7'h00, oe});
    @(posedge clk_in);
    rdr(`GSPS_REG_IRQ_STAT, d);
    wrr(`GSPS_REG_SEL2, 8'h08);
    lv <= 6'h01;
    pin(1'b1);
    cmp(8'h00, {7'h00, irq});
    rdr(`GSPS_REG_PINS, d);
    cmp(8'h04, d & 8'h04);
    wrr(`GSPS_REG_IRQ_MASK, 8'h04);
    see(2);
    cmp(8'h01, {7'h00, irq});
    @(posedge clk_in);
    rdr(`GSPS_REG_IRQ_STAT, d);
    cmp(8'h04, d & 8'h04);
    see(2);
    cmp(8'h00, {7'h00, irq});
    tally_and_finish();
  end
endmodule : gsps_status_pins_tb_top
